/* common/rwm_defines.vh */
/*
 * Constants for the RAM window map and identification register block:
 * register offsets, window geometry, variant codes and fixed read values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef RWM_DEFINES_VH
`define RWM_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices; software reaches each at four times its index.
// ----------------------------------------------------------------------
`define RWM_IDX_PART_ID_HIGH   8'h1A
`define RWM_IDX_PART_ID_LOW    8'h1B
`define RWM_IDX_MEM_SIZE_FIRST 8'h1C
`define RWM_IDX_MEM_SIZE_SECOND 8'h1D
`define RWM_IDX_WINDOW_POS     8'h10
`define RWM_IDX_MAP_STATUS     8'h11
`define RWM_IDX_PROBE_ADDR     8'h12

// ----------------------------------------------------------------------
// Window position register fields.
// ----------------------------------------------------------------------
`define RWM_POS_WIN_HI         7
`define RWM_POS_WIN_LO         6
`define RWM_POS_BIT_A          5
`define RWM_POS_BIT_B          4
`define RWM_POS_BIT_C          3
`define RWM_POS_TOP_ALIGN      0
`define RWM_POS_RESET          8'h00
`define RWM_POS_WRITE_MASK     8'hF9

// ----------------------------------------------------------------------
// Window geometry, in 2 KB pages of a 16 KB quarter (12 KB window).
// ----------------------------------------------------------------------
`define RWM_WIN_PAGES          3'h6
`define RWM_PAGES_6K           3'h3
`define RWM_PAGES_4K           3'h2
`define RWM_PAGES_2K           3'h1
`define RWM_TOP_SHIFT          3'h2

// ----------------------------------------------------------------------
// RAM variant codes and fixed memory size values.
// ----------------------------------------------------------------------
`define RWM_VAR_6K             2'h0
`define RWM_VAR_4K             2'h1
`define RWM_VAR_2K             2'h2
`define RWM_MEMSZ0_FLASH       8'h15
`define RWM_MEMSZ1_FLASH       8'h81
`define RWM_MEMSZ0_ROM         8'h01
`define RWM_MEMSZ1_ROM         8'h80

// Identification code; the value is arbitrary.
`define RWM_PART_ID            16'hA5C3

`endif

/* rtl/rwm_ram_window_map.v */
/*
 * RAM window map and identification registers behind an APB slave.
 * Decodes a 16-bit CPU address into RAM hit, reserved hit or pass-on,
 * holds the window position register, and serves read-only part ID and
 * memory size values. Drives the mode-select pull-down enables.
 * Assumes an APB master on clk_sys, and a reset pin level that is
 * asynchronous to clk_sys.
 */
`include "rwm_defines.vh"

module rwm_ram_window_map #(
	parameter [1:0]  RAM_VARIANT = `RWM_VAR_6K,  // RAM size variant.
	parameter        ROM_GROUP   = 0,            // 1 selects ROM group.
	parameter [15:0] PART_ID     = `RWM_PART_ID  // Arbitrary ID value.
) (
	input  wire        clk_sys,       // System clock, 250 MHz.
	input  wire        rstn,          // Asynchronous reset, active low.
	input  wire        psel,          // APB select.
	input  wire        penable,       // APB enable.
	input  wire        pwrite,        // APB write.
	input  wire [11:0] paddr,         // APB byte address.
	input  wire [31:0] pwdata,        // APB write data.
	input  wire [3:0]  pstrb,         // APB byte strobes.
	output reg  [31:0] prdata,        // APB read data.
	output reg         pready,        // APB ready.
	output reg         pslverr,       // APB error.
	input  wire        cpu_valid,     // CPU access request.
	input  wire [15:0] cpu_addr,      // CPU access address.
	output reg         ram_sel_ff,    // Access hits RAM.
	output reg  [13:0] ram_offs_ff,   // Byte offset inside RAM.
	output reg         rsvd_hit_ff,   // Access hits reserved space.
	output reg         array_sel_ff,  // Access may go to arrays.
	input  wire        reset_pin,     // External reset pin level.
	output reg         mode_pd_a_ff,  // Pull-down on mode_select_a.
	output reg         mode_pd_b_ff   // Pull-down on mode_select_b.
);

	// ------------------------------------------------------------------
	// Window position register and derived geometry.
	// ------------------------------------------------------------------
	reg  [7:0]  ram_window_position_ff;
	reg  [7:0]  nxt_ram_window_position;
	reg  [2:0]  ram_pages;
	reg  [2:0]  ram_first_page;
	wire [1:0]  win_quarter;
	wire        ram_top_align_select;
	wire        ram_pos_bit_a;
	wire        ram_pos_bit_b;
	wire        ram_pos_bit_c;
	reg         align_ok;

	assign win_quarter = ram_window_position_ff[`RWM_POS_WIN_HI:
		`RWM_POS_WIN_LO];
	assign ram_top_align_select =
		ram_window_position_ff[`RWM_POS_TOP_ALIGN];
	assign ram_pos_bit_a = ram_window_position_ff[`RWM_POS_BIT_A];
	assign ram_pos_bit_b = ram_window_position_ff[`RWM_POS_BIT_B];
	assign ram_pos_bit_c = ram_window_position_ff[`RWM_POS_BIT_C];

	// Pages are 2 KB. The window holds six pages starting at the quarter
	// base, or at base plus two pages when aligned to the top, so the
	// window always ends at the quarter's upper boundary then.
	always @* begin
		ram_pages = `RWM_PAGES_6K;
		align_ok  = (ram_pos_bit_a == ram_top_align_select);
		if (RAM_VARIANT == `RWM_VAR_4K) begin
			ram_pages = `RWM_PAGES_4K;
			align_ok  = align_ok &&
				(ram_pos_bit_b == ram_top_align_select);
		end else if (RAM_VARIANT == `RWM_VAR_2K) begin
			ram_pages = `RWM_PAGES_2K;
			align_ok  = align_ok &&
				(ram_pos_bit_b == ram_top_align_select) &&
				(ram_pos_bit_c == ram_top_align_select);
		end
		if (ram_top_align_select) begin
			ram_first_page = `RWM_TOP_SHIFT + `RWM_WIN_PAGES
				- ram_pages;
		end else begin
			ram_first_page = 3'h0;
		end
	end

	// ------------------------------------------------------------------
	// CPU address decode.
	// ------------------------------------------------------------------
	wire [2:0]  cpu_page;
	wire        in_quarter;
	reg  [2:0]  win_page;
	reg         in_window;
	reg         in_ram;
	reg  [2:0]  ram_page;
	reg  [3:0]  win_end;
	reg  [3:0]  ram_end;

	assign cpu_page   = cpu_addr[13:11];
	assign in_quarter = (cpu_addr[15:14] == win_quarter);

	// End pages are one bit wider: a top-aligned window or RAM ends at
	// page eight, which a three-bit sum would wrap to zero.
	always @* begin
		win_page  = ram_top_align_select ? `RWM_TOP_SHIFT : 3'h0;
		win_end   = {1'b0, win_page} + {1'b0, `RWM_WIN_PAGES};
		ram_end   = {1'b0, ram_first_page} + {1'b0, ram_pages};
		in_window = in_quarter && (cpu_page >= win_page) &&
			({1'b0, cpu_page} < win_end);
		in_ram    = in_quarter && (cpu_page >= ram_first_page) &&
			({1'b0, cpu_page} < ram_end);
		ram_page  = cpu_page - ram_first_page;
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ram_sel_ff   <= 1'b0;
			ram_offs_ff  <= 14'h0000;
			rsvd_hit_ff  <= 1'b0;
			array_sel_ff <= 1'b0;
		end else begin
			ram_sel_ff   <= cpu_valid && in_ram;
			ram_offs_ff  <= {ram_page, cpu_addr[10:0]};
			rsvd_hit_ff  <= cpu_valid && in_window && !in_ram;
			array_sel_ff <= cpu_valid && !in_window;
		end
	end

	// ------------------------------------------------------------------
	// Mode-select pull-downs follow the synchronised reset pin.
	// ------------------------------------------------------------------
	wire reset_pin_s;

	rwm_sync2 u_sync_reset_pin (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d_in    (reset_pin),
		.q_out   (reset_pin_s)
	);

	// Both pull-downs start enabled: the part is in reset at power up.
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_pd_a_ff <= 1'b1;
			mode_pd_b_ff <= 1'b1;
		end else begin
			mode_pd_a_ff <= !reset_pin_s;
			mode_pd_b_ff <= !reset_pin_s;
		end
	end

	// ------------------------------------------------------------------
	// APB slave: one wait state; pready follows the first access cycle.
	// ------------------------------------------------------------------
	wire [9:0]  reg_idx;
	wire        word_ok;
	wire        acc_phase;
	reg  [7:0]  rd_byte;
	reg         hit;
	reg         writable;
	reg  [7:0]  probe_ff;

	assign reg_idx   = paddr[11:2];
	assign word_ok   = (paddr[1:0] == 2'h0);
	assign acc_phase = psel && penable && !pready;

	always @* begin
		rd_byte  = 8'h00;
		hit      = word_ok;
		writable = 1'b0;
		if (reg_idx == {2'h0, `RWM_IDX_PART_ID_HIGH}) begin
			rd_byte = PART_ID[15:8];
		end else if (reg_idx == {2'h0, `RWM_IDX_PART_ID_LOW}) begin
			rd_byte = PART_ID[7:0];
		end else if (reg_idx == {2'h0, `RWM_IDX_MEM_SIZE_FIRST}) begin
			rd_byte = (ROM_GROUP != 0) ? `RWM_MEMSZ0_ROM
				: `RWM_MEMSZ0_FLASH;
		end else if (reg_idx == {2'h0, `RWM_IDX_MEM_SIZE_SECOND}) begin
			rd_byte = (ROM_GROUP != 0) ? `RWM_MEMSZ1_ROM
				: `RWM_MEMSZ1_FLASH;
		end else if (reg_idx == {2'h0, `RWM_IDX_WINDOW_POS}) begin
			rd_byte  = ram_window_position_ff;
			writable = 1'b1;
		end else if (reg_idx == {2'h0, `RWM_IDX_MAP_STATUS}) begin
			rd_byte = {align_ok, rsvd_hit_ff, ram_sel_ff, array_sel_ff,
				1'b0, (ROM_GROUP != 0), RAM_VARIANT};
		end else if (reg_idx == {2'h0, `RWM_IDX_PROBE_ADDR}) begin
			rd_byte = probe_ff;
		end else begin
			hit = 1'b0;
		end
	end

	// Writes to read-only registers are refused with pslverr so that
	// software notices an attempt to alter the identification bytes.
	always @* begin
		nxt_ram_window_position = ram_window_position_ff;
		if (acc_phase && pwrite && hit && writable && pstrb[0]) begin
			nxt_ram_window_position = pwdata[7:0] & `RWM_POS_WRITE_MASK;
		end
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ram_window_position_ff <= `RWM_POS_RESET;
			probe_ff               <= 8'h00;
			prdata                 <= 32'h00000000;
			pready                 <= 1'b0;
			pslverr                <= 1'b0;
		end else begin
			ram_window_position_ff <= nxt_ram_window_position;
			probe_ff <= {ram_first_page, ram_pages, win_quarter};
			pready   <= acc_phase;
			pslverr  <= acc_phase && (!hit || (pwrite && !writable));
			if (acc_phase && !pwrite && hit) begin
				prdata <= {24'h000000, rd_byte};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

endmodule // rwm_ram_window_map

/* rtl/rwm_sync2.v */
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes clk_sys and an asynchronous active-low reset.
 */
module rwm_sync2 (
	input  wire clk_sys, // System clock.
	input  wire rstn,    // Asynchronous reset, active low.
	input  wire d_in,    // Asynchronous level.
	output wire q_out    // Synchronised level.
);
	reg meta_ff;
	reg sync_ff;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule // rwm_sync2

/* sim/ram_window_map_and_id_tb_top.sv */
/* Bench for the RAM window map: fixed registers, decode sweep, pull-downs.
   Runs 6 KB, 4 KB and 2 KB copies side by side; APB has one wait state. */
`include "rwm_defines.vh"
module ram_window_map_and_id_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic cpu_valid = 0, reset_pin = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, lfsr = 32'h1EC8AD94;
	logic [15:0] cpu_addr = 0, id = `RWM_PART_ID;
	// Index 0: 6 KB flash group, 1: 4 KB flash group, 2: 2 KB ROM group.
	logic [31:0] prd[3], rd[3];
	logic [13:0] offs[3];
	logic prdy[3], perr[3], err[3], ram_hit[3], rsvd_hit[3], arr_hit[3];
	logic pd_a[3], pd_b[3];
	int err_count = 0, comparisons = 0;
	for (genvar g = 0; g < 3; g++) begin : g_dut
		rwm_ram_window_map #(.RAM_VARIANT(2'(g)), .ROM_GROUP(g / 2)) dut (
			.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
			.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
			.prdata(prd[g]), .pready(prdy[g]), .pslverr(perr[g]),
			.cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
			.ram_sel_ff(ram_hit[g]), .ram_offs_ff(offs[g]),
			.rsvd_hit_ff(rsvd_hit[g]), .array_sel_ff(arr_hit[g]),
			.reset_pin(reset_pin), .mode_pd_a_ff(pd_a[g]),
			.mode_pd_b_ff(pd_b[g]));
	end
	initial forever #2 clk_sys = ~clk_sys;
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Called right after an edge; one idle cycle follows each transfer.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (prdy[0] !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			finish_test();
		end
		for (int k = 0; k < 3; k++) begin
			check(prdy[k], 1'b1);
			rd[k] = prd[k];
			err[k] = perr[k];
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	function automatic logic [15:0] ram_size(input int k);
		return (k == 0) ? 16'h1800 : ((k == 1) ? 16'h1000 : 16'h0800);
	endfunction
	function automatic logic [7:0] reg_exp(input int i, input int k);
		case (i)
			0: return id[15:8];
			1: return id[7:0];
			2: return (k == 2) ? 8'h01 : 8'h15;
			default: return (k == 2) ? 8'h80 : 8'h81;
		endcase
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected hits come from the window position alone, wrap included.
	task automatic dec(input logic [15:0] a, input logic [7:0] pos);
		logic [15:0] lo, rl, sz, ofs;
		cpu_addr <= a;
		repeat (2) @(posedge clk_sys);
		lo = {pos[7:6], 14'h0} + (pos[0] ? 16'h1000 : 16'h0);
		for (int k = 0; k < 3; k++) begin
			sz = ram_size(k);
			rl = {pos[7:6], 14'h0} + (pos[0] ? 16'h4000 - sz : 16'h0);
			ofs = a - rl;
			if (!pos[0]) check(ram_hit[k], ofs < sz);
			else check(ram_hit[k], ofs < sz);
			check(rsvd_hit[k], a - lo < 16'h3000 && ofs >= sz);
			check(arr_hit[k], a - lo >= 16'h3000);
			check(ram_hit[k] ? offs[k] : 14'h0, ofs < sz ? ofs : 16'h0);
		end
	endtask
	initial begin
		logic [11:0] ra[4];
		logic [13:0] off[14];
		logic [7:0]  pos;
		logic [7:0]  v;
		ra = '{12'h068, 12'h06C, 12'h070, 12'h074};
		off = '{14'h0, 14'h7FF, 14'h800, 14'hFFF, 14'h1000,
			14'h17FF, 14'h1800, 14'h27FF, 14'h2800, 14'h2FFF, 14'h3000,
			14'h37FF, 14'h3800, 14'h3FFF};
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 3; k++) begin
			check({pd_a[k], pd_b[k]}, 2'b11);
		end
		rstn <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ra[i], 32'h0);
			for (int k = 0; k < 3; k++) begin
				v = reg_exp(i, k);
				if (i < 2) check({err[k], rd[k]}, {25'h0, v});
				else check({err[k], rd[k]}, {25'h0, v});
			end
			apb(1'b1, ra[i], 32'hFF);
			for (int k = 0; k < 3; k++) begin
				check(err[k], 1'b1);
			end
			apb(1'b0, ra[i], 32'h0);
			for (int k = 0; k < 3; k++) begin
				v = reg_exp(i, k);
				check(rd[k], {24'h0, v});
			end
		end
		apb(1'b0, 12'h07C, 32'h0);
		for (int k = 0; k < 3; k++) begin
			check({err[k], rd[k]}, 33'h100000000);
		end
		apb(1'b0, 12'h069, 32'h0);
		for (int k = 0; k < 3; k++) begin
			check({err[k], rd[k]}, 33'h100000000);
		end
		$display("register reads done");
		cpu_valid <= 1'b1;
		for (int q = 0; q < 8; q++) begin
			pos = {q[1:0], q[2] ? 6'h39 : 6'h00};
			apb(1'b1, 12'h040, {24'h0, pos});
			apb(1'b0, 12'h040, 32'h0);
			for (int k = 0; k < 3; k++) begin
				check(rd[k], {24'h0, pos});
			end
			// Status: position bits consistent, group and variant code.
			apb(1'b0, 12'h044, 32'h0);
			for (int k = 0; k < 3; k++) begin
				check({rd[k][7], rd[k][3:0]}, {1'b1, 1'b0, k == 2, 2'(k)});
			end
			dec({pos[7:6], 14'h0} - 16'h1, pos);
			foreach (off[j]) dec({pos[7:6], off[j]}, pos);
			repeat (8) begin
				lfsr = lfsr_next(lfsr);
				dec(lfsr[15:0], pos);
			end
		end
		$display("decode sweep done");
		reset_pin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 3; k++) begin
			check({pd_a[k], pd_b[k]}, 2'b11);
		end
		reset_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 3; k++) begin
			check({pd_a[k], pd_b[k]}, 2'b00);
		end
		$display("pull-down test done");
		finish_test();
	end
endmodule // ram_window_map_and_id_tb_top

/* sim/rwm_checker.sv */
/* Checker for the RAM window map block: APB timing, fixed reads, pull-downs.
   Bound to the top module; sees its ports only. */
module rwm_checker #(
	parameter        ROM_GROUP = 0,     // Memory size group.
	parameter [15:0] PART_ID   = 16'h0  // Identification value.
) (
	input logic        clk_sys,      // Clock.
	input logic        rstn,         // Reset, active low.
	input logic        psel,         // APB select.
	input logic        penable,      // APB enable.
	input logic        pwrite,       // APB write.
	input logic [11:0] paddr,        // APB address.
	input logic [31:0] prdata,       // APB read data.
	input logic        pready,       // APB ready.
	input logic        pslverr,      // APB error.
	input logic        ram_sel_ff,   // RAM hit.
	input logic        rsvd_hit_ff,  // Reserved hit.
	input logic        array_sel_ff, // Array pass-on.
	input logic        reset_pin,    // Reset pin level.
	input logic        mode_pd_a_ff, // Pull-down a.
	input logic        mode_pd_b_ff  // Pull-down b.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire rd_ok = psel && pready && !pwrite && !pslverr;
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	chk_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside ready cycle");
	chk_one_hit: assert property ($onehot0({ram_sel_ff, rsvd_hit_ff,
		array_sel_ff})) else $error("decode hits overlap");
	chk_id_high: assert property (rd_ok && paddr == 12'h068
		|-> prdata == {24'h0, PART_ID[15:8]}) else $error("id high wrong");
	chk_id_low: assert property (rd_ok && paddr == 12'h06C
		|-> prdata == {24'h0, PART_ID[7:0]}) else $error("id low wrong");
	chk_size_first: assert property (rd_ok && paddr == 12'h070
		|-> prdata[7:0] == (ROM_GROUP ? 8'h01 : 8'h15)) else $error("size0");
	chk_size_second: assert property (rd_ok && paddr == 12'h074
		|-> prdata[7:0] == (ROM_GROUP ? 8'h80 : 8'h81)) else $error("size1");
	chk_pd_on: assert property (!reset_pin [*4]
		|-> mode_pd_a_ff && mode_pd_b_ff) else $error("pull-down off");
	// Five samples: the attempt at the release edge still sees held flops.
	chk_pd_off: assert property (reset_pin [*5]
		|-> !mode_pd_a_ff && !mode_pd_b_ff) else $error("pull-down on");
	cover property (pslverr);
	cover property (ram_sel_ff);
	cover property (rsvd_hit_ff);
endmodule // rwm_checker

bind rwm_ram_window_map rwm_checker #(.ROM_GROUP(ROM_GROUP),
	.PART_ID(PART_ID)) u_chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ram_sel_ff(ram_sel_ff),
	.rsvd_hit_ff(rsvd_hit_ff), .array_sel_ff(array_sel_ff),
	.reset_pin(reset_pin), .mode_pd_a_ff(mode_pd_a_ff),
	.mode_pd_b_ff(mode_pd_b_ff));
